// ### hw/rlc_link_ctl.sv
// radio link settings: command port, transmit timer, retries, crc filter
//
// Contract
// [RULE1] mode codes 04/06/07, 14/16/17 add acknowledge
// [RULE2] acknowledge switchable in every networking mode
// [RULE3] host byte starts or restarts ms countdown
// [RULE4] countdown loads timeout setting, reset 0x10
// [RULE5] countdown at zero sends buffered bytes
// [RULE6] host keeps timeout at least 2, never 1
// [RULE7] timeout zero: send once buffer reaches unit
// [RULE8] resend unacknowledged packet up to retry setting
// [RULE9] no acknowledge after last retry raises exception
// [RULE10] acknowledge wait time chosen by baud rate
// [RULE11] crc enabled: failing packets are dropped
// [RULE12] crc setting 1 enables, 0 disables, default on
// [RULE13] settings at volatile and non-volatile addresses
// [RULE14] transmission unit 1 to 192 is threshold
// [RULE15] crc failures counted, host zero write clears
// [RULE16] framed read and write commands with reply
`timescale 1ns/1ps
`include "rlc_consts.svh"
module rlc_link_ctl import rlc_pkg::*; #(
  parameter int MS_CYCLES = `RLC_MS_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cmd_mode,
  input wire rlc_byte_t host_in,
  input wire logic reply_ready,
  input wire logic radio_ack,
  input wire logic rx_pkt_end,
  input wire logic rx_crc_ok,
  output rlc_byte_t reply_out,
  output rlc_cfg_t cfg_r,
  output logic tx_start_r,
  output logic retx_r,
  output logic no_radio_ack_exception,
  output logic rx_forward_r,
  output logic rx_discard_r,
  output logic [7:0] buf_level_r
);
  typedef enum {P_HDR, P_SIZE, P_ADDR, P_RADDR, P_WVAL, P_REPLY} rlc_pstate_t;
  typedef enum {TX_IDLE, TX_WAIT_ACK} rlc_txstate_t;

  rlc_pstate_t pstate_r; // command parser state
  rlc_txstate_t txstate_r; // transmit/acknowledge state
  logic [7:0] addr_r; // address under command
  logic [1:0] reply_idx_r; // byte of reply being offered
  logic [7:0] netmode_r, txto_r, retry_r, crcen_r, mtu_r, baud_r; // volatile settings
  logic [7:0] nv_r [0:5]; // non-volatile images, order as nv_index
  logic [7:0] crc_cnt_r; // crc failure counter
  logic [7:0] retries_used_r; // resends done for current packet
  logic flush_pend_r; // countdown ran out, send owed
  logic [15:0] ms_div_r; // millisecond prescaler
  logic ms_tick_r; // one pulse per millisecond
  logic [7:0] txto_cnt, ack_cnt; // timer counts
  logic txto_exp, ack_exp; // timer expiry pulses
  logic wr_stb; // a write command completes this cycle
  logic [7:0] wr_val; // its value
  logic data_stb; // a payload byte enters the buffer
  logic send_now; // launch a packet this cycle
  logic ack_load; // arm or stop the acknowledge timer

  // networking mode codes accepted by the mode register
  function automatic logic mode_ok(input logic [7:0] v);
    logic [7:0] b;
    b = v & ~(8'h01 << `RLC_NM_ACK_BIT);
    mode_ok = (v[7:5] == 3'h0) && (b == `RLC_NM_GUID || b == `RLC_NM_USER || b == `RLC_NM_EXT);
  endfunction

  // acknowledge flag of a mode code
  function automatic logic mode_ack(input logic [7:0] v);
    mode_ack = v[`RLC_NM_ACK_BIT];
  endfunction

  // acknowledge wait in ms; slow rates get longer air time
  function automatic logic [7:0] ack_wait_ms(input logic [7:0] baud);
    case (baud)
      8'h00: ack_wait_ms = `RLC_ACKW_2400;
      8'h01: ack_wait_ms = `RLC_ACKW_9600;
      8'h06: ack_wait_ms = `RLC_ACKW_9600; // 10400 sits with 9600
      8'h02: ack_wait_ms = `RLC_ACKW_19200;
      default: ack_wait_ms = `RLC_ACKW_FAST;
    endcase
  endfunction

  // map of a non-volatile address to its image slot, 7 when unmapped
  function automatic logic [2:0] nv_index(input logic [7:0] a);
    case (a)
      `RLC_NV_NETMODE: nv_index = 3'd0;
      `RLC_NV_TXTO: nv_index = 3'd1;
      `RLC_NV_RETRY: nv_index = 3'd2;
      `RLC_NV_CRCEN: nv_index = 3'd3;
      `RLC_NV_MTU: nv_index = 3'd4;
      `RLC_NV_BAUD: nv_index = 3'd5;
      default: nv_index = 3'd7;
    endcase
  endfunction

  // read value of any address; unmapped reads as zero
  function automatic logic [7:0] rd_value(input logic [7:0] a);
    logic [2:0] i;
    i = nv_index(a);
    case (a)
      `RLC_A_NETMODE: rd_value = netmode_r;
      `RLC_A_TXTO: rd_value = txto_r;
      `RLC_A_RETRY: rd_value = retry_r;
      `RLC_A_CRCEN: rd_value = crcen_r;
      `RLC_A_MTU: rd_value = mtu_r;
      `RLC_A_BAUD: rd_value = baud_r;
      `RLC_A_CRCCNT: rd_value = crc_cnt_r;
      default: rd_value = (i == 3'd7) ? 8'h00 : nv_r[i];
    endcase
  endfunction

  assign wr_stb = host_in.valid && cmd_mode && pstate_r == P_WVAL;
  assign wr_val = host_in.data;
  assign data_stb = host_in.valid && !cmd_mode;
  // only idle launches; flush owed by timer, or unit reached with timer off
  assign send_now = txstate_r == TX_IDLE && buf_level_r != 8'h00 && !tx_start_r && // [RULE5] [RULE7] [RULE14]
                    ((txto_r != 8'h00 && flush_pend_r) || (txto_r == 8'h00 && buf_level_r >= mtu_r));
  assign ack_load = send_now || (txstate_r == TX_WAIT_ACK && (radio_ack || ack_exp));

  // millisecond prescaler
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ms_div_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_div_r == 16'(MS_CYCLES - 1));
      ms_div_r <= (ms_div_r == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_div_r + 16'h0001;
    end
  end

  // transmit wait countdown, reloaded by every payload byte
  rlc_ms_countdown u_txto (
    .mclk(mclk),
    .resetn(resetn),
    .load(data_stb), // [RULE3]
    .load_val(txto_r), // [RULE4]
    .ms_tick(ms_tick_r),
    .count(txto_cnt),
    .expired(txto_exp)
  );

  // acknowledge wait; a zero load stops it once answered
  rlc_ms_countdown u_ackw (
    .mclk(mclk),
    .resetn(resetn),
    .load(ack_load),
    .load_val((send_now || (ack_exp && cfg_r.ack_en && retries_used_r < retry_r)) ?
              ack_wait_ms(baud_r) : 8'h00), // [RULE10]
    .ms_tick(ms_tick_r),
    .count(ack_cnt),
    .expired(ack_exp)
  );

  // command parser and reply sequencing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pstate_r <= P_HDR;
      addr_r <= 8'h00;
      reply_idx_r <= 2'd0;
      reply_out <= '0;
    end else begin
      case (pstate_r)
        P_HDR: if (host_in.valid && cmd_mode && host_in.data == `RLC_HDR_BYTE) begin
          pstate_r <= P_SIZE; // [RULE16]
        end
        P_SIZE: if (host_in.valid && cmd_mode) begin
          pstate_r <= (host_in.data == `RLC_SIZE_BYTE) ? P_ADDR : P_HDR;
        end
        P_ADDR: if (host_in.valid && cmd_mode) begin
          // escape marks a read; anything else is a write address
          if (host_in.data == `RLC_ESC_BYTE) begin
            pstate_r <= P_RADDR;
          end else begin
            addr_r <= host_in.data;
            pstate_r <= P_WVAL;
          end
        end
        P_RADDR: if (host_in.valid && cmd_mode) begin
          addr_r <= host_in.data;
          reply_idx_r <= 2'd0;
          reply_out <= '{valid: 1'b1, data: `RLC_REPLY_ACK}; // [RULE16]
          pstate_r <= P_REPLY;
        end
        P_WVAL: if (host_in.valid && cmd_mode) begin
          pstate_r <= P_HDR;
        end
        P_REPLY: if (reply_ready) begin
          // host bytes arriving while the reply drains are not parsed
          reply_idx_r <= reply_idx_r + 2'd1;
          case (reply_idx_r)
            2'd0: reply_out <= '{valid: 1'b1, data: addr_r};
            2'd1: reply_out <= '{valid: 1'b1, data: rd_value(addr_r)};
            default: begin
              reply_out <= '0;
              pstate_r <= P_HDR;
            end
          endcase
        end
        default: pstate_r <= P_HDR;
      endcase
    end
  end

  // setting registers; illegal values are dropped so state stays valid
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      netmode_r <= `RLC_RST_NETMODE;
      txto_r <= `RLC_RST_TXTO; // [RULE4]
      retry_r <= `RLC_RST_RETRY;
      crcen_r <= `RLC_RST_CRCEN; // [RULE12]
      mtu_r <= `RLC_RST_MTU;
      baud_r <= `RLC_RST_BAUD;
    end else if (wr_stb) begin
      case (addr_r)
        `RLC_A_NETMODE: if (mode_ok(wr_val)) netmode_r <= wr_val; // [RULE1] [RULE13]
        `RLC_A_TXTO: txto_r <= wr_val;
        `RLC_A_RETRY: retry_r <= wr_val;
        `RLC_A_CRCEN: if (wr_val[7:1] == 7'h00) crcen_r <= wr_val; // [RULE12]
        `RLC_A_MTU: if (wr_val >= `RLC_MTU_MIN && wr_val <= `RLC_MTU_MAX) mtu_r <= wr_val; // [RULE14]
        `RLC_A_BAUD: baud_r <= wr_val;
        default: ;
      endcase
    end
  end

  // non-volatile images: stored only, they steer nothing and a reset returns them to the defaults
  generate
    for (genvar g = 0; g < 6; g++) begin : g_nv
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          nv_r[g] <= (g == 0) ? `RLC_RST_NETMODE : (g == 1) ? `RLC_RST_TXTO : (g == 2) ? `RLC_RST_RETRY :
                     (g == 3) ? `RLC_RST_CRCEN : (g == 4) ? `RLC_RST_MTU : `RLC_RST_BAUD;
        end else if (wr_stb && nv_index(addr_r) == 3'(g)) begin
          nv_r[g] <= wr_val; // [RULE13]
        end
      end
    end
  endgenerate

  // decoded live configuration
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= '{mode: RLC_MODE_GUID, ack_en: 1'b0, crc_en: 1'b1};
    end else begin
      cfg_r.ack_en <= mode_ack(netmode_r); // [RULE2]
      cfg_r.crc_en <= crcen_r[0]; // [RULE12]
      cfg_r.mode <= (netmode_r[2:0] == 3'h4) ? RLC_MODE_GUID :
                    (netmode_r[2:0] == 3'h6) ? RLC_MODE_USER : RLC_MODE_EXT; // [RULE1]
    end
  end

  // buffer level and owed flush
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      buf_level_r <= 8'h00;
      flush_pend_r <= 1'b0;
    end else begin
      if (send_now) begin
        buf_level_r <= data_stb ? 8'h01 : 8'h00;
      end else if (data_stb && buf_level_r != 8'hFF) begin
        buf_level_r <= buf_level_r + 8'h01;
      end
      // expiry sets; a send or a payload byte clears; set wins when both fall together
      if (txto_exp && txto_r != 8'h00) begin
        flush_pend_r <= 1'b1; // [RULE5]
      end else if (send_now || data_stb) begin
        flush_pend_r <= 1'b0;
      end
    end
  end

  // send, wait for acknowledge, retry, give up
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txstate_r <= TX_IDLE;
      tx_start_r <= 1'b0;
      retx_r <= 1'b0;
      no_radio_ack_exception <= 1'b0;
      retries_used_r <= 8'h00;
    end else begin
      tx_start_r <= send_now;
      retx_r <= 1'b0;
      no_radio_ack_exception <= 1'b0;
      case (txstate_r)
        TX_IDLE: if (send_now && cfg_r.ack_en) begin
          txstate_r <= TX_WAIT_ACK;
          retries_used_r <= 8'h00;
        end
        TX_WAIT_ACK: if (radio_ack) begin
          txstate_r <= TX_IDLE;
        end else if (ack_exp) begin
          if (retries_used_r < retry_r) begin
            retries_used_r <= retries_used_r + 8'h01;
            retx_r <= 1'b1; // [RULE8]
          end else begin
            no_radio_ack_exception <= 1'b1; // [RULE9]
            txstate_r <= TX_IDLE;
          end
        end
        default: txstate_r <= TX_IDLE;
      endcase
    end
  end

  // received packet filter and failure counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_forward_r <= 1'b0;
      rx_discard_r <= 1'b0;
      crc_cnt_r <= 8'h00;
    end else begin
      rx_forward_r <= rx_pkt_end && (rx_crc_ok || !cfg_r.crc_en);
      rx_discard_r <= rx_pkt_end && !rx_crc_ok && cfg_r.crc_en; // [RULE11]
      // a failure in the clearing cycle still counts
      if (rx_pkt_end && !rx_crc_ok) begin
        crc_cnt_r <= (wr_stb && addr_r == `RLC_A_CRCCNT && wr_val == 8'h00) ? 8'h01 :
                     (crc_cnt_r == 8'hFF) ? crc_cnt_r : crc_cnt_r + 8'h01; // [RULE15]
      end else if (wr_stb && addr_r == `RLC_A_CRCCNT && wr_val == 8'h00) begin
        crc_cnt_r <= 8'h00; // [RULE15]
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_send_armed;
    tx_start_r ##0 (ack_cnt == ack_wait_ms($past(baud_r)));
  endsequence
  sequence s_nm_write;
    wr_stb && addr_r == `RLC_A_NETMODE && mode_ok(wr_val);
  endsequence

  a_mode_decode: assert property (s_nm_write |=> ##1 cfg_r.ack_en == $past(wr_val[4], 2)) // [RULE1] [RULE2]
    else $error("ack flag not decoded from mode write");
  a_timer_restart: assert property (data_stb |=> txto_cnt == $past(txto_r)) // [RULE3] [RULE4]
    else $error("countdown not reloaded by host byte");
  a_flush_cause: assert property (tx_start_r && txto_r != 8'h00 |-> $past(flush_pend_r)) // [RULE5]
    else $error("send without countdown expiry");
  a_mtu_trigger: assert property (txstate_r == TX_IDLE && !tx_start_r && txto_r == 8'h00 &&
                                  buf_level_r >= mtu_r && buf_level_r != 8'h00 |=> tx_start_r) // [RULE7] [RULE14]
    else $error("unit reached but no send");
  a_ack_armed: assert property (send_now && cfg_r.ack_en |=> s_send_armed) // [RULE10]
    else $error("acknowledge wait not baud based");
  a_retry_bound: assert property (retx_r |-> retries_used_r <= retry_r && retries_used_r != 8'h00) // [RULE8]
    else $error("retry beyond limit");
  a_exc_cause: assert property (no_radio_ack_exception |-> // [RULE9]
                                $past(ack_exp) && $past(retries_used_r) == $past(retry_r))
    else $error("exception without final retry timeout");
  a_crc_drop: assert property (rx_pkt_end && !rx_crc_ok && cfg_r.crc_en |=> rx_discard_r && !rx_forward_r) // [RULE11]
    else $error("failing packet forwarded");
  a_crc_count: assert property (rx_pkt_end && !rx_crc_ok && !wr_stb && crc_cnt_r != 8'hFF |=>
                                crc_cnt_r == $past(crc_cnt_r) + 8'h01) // [RULE15]
    else $error("crc failure not counted");
  a_read_reply: assert property (pstate_r == P_RADDR && host_in.valid && cmd_mode |=>
                                 reply_out.valid && reply_out.data == `RLC_REPLY_ACK) // [RULE16]
    else $error("read reply does not open with ack");
endmodule

// ### inc/rlc_consts.svh
// constants for the radio link control settings block
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH
// command framing bytes
`define RLC_HDR_BYTE 8'hFF
`define RLC_SIZE_BYTE 8'h02
`define RLC_ESC_BYTE 8'hFE
`define RLC_REPLY_ACK 8'h06
// volatile addresses
`define RLC_A_CRCCNT 8'h40
`define RLC_A_BAUD 8'h4E
`define RLC_A_NETMODE 8'h4F
`define RLC_A_TXTO 8'h50
`define RLC_A_RETRY 8'h52
`define RLC_A_CRCEN 8'h53
`define RLC_A_MTU 8'h54
// non-volatile addresses
`define RLC_NV_BAUD 8'h03
`define RLC_NV_NETMODE 8'h04
`define RLC_NV_TXTO 8'h05
`define RLC_NV_RETRY 8'h07
`define RLC_NV_CRCEN 8'h08
`define RLC_NV_MTU 8'h09
// networking mode codes and acknowledge bit position
`define RLC_NM_GUID 8'h04
`define RLC_NM_USER 8'h06
`define RLC_NM_EXT 8'h07
`define RLC_NM_ACK_BIT 4
// reset values
`define RLC_RST_NETMODE 8'h04
`define RLC_RST_TXTO 8'h10
`define RLC_RST_RETRY 8'h03
`define RLC_RST_CRCEN 8'h01
`define RLC_RST_MTU 8'h40
`define RLC_RST_BAUD 8'h01
// minimum transmission unit bounds
`define RLC_MTU_MIN 8'h01
`define RLC_MTU_MAX 8'hC0
// timing: clock rate, millisecond, acknowledge waits in ms
`define RLC_CLK_HZ 50000000
`define RLC_MS_PER_S 1000
`define RLC_MS_CYCLES (`RLC_CLK_HZ / `RLC_MS_PER_S)
`define RLC_ACKW_2400 8'hAA
`define RLC_ACKW_9600 8'h4B
`define RLC_ACKW_19200 8'h2D
`define RLC_ACKW_FAST 8'h1E
`endif

// ### inc/rlc_pkg.sv
// types shared by the radio link control settings block
package rlc_pkg;
  // decoded networking mode
  typedef enum logic [1:0] {RLC_MODE_GUID, RLC_MODE_USER, RLC_MODE_EXT} rlc_mode_t;
  // live link configuration carried to the radio engine
  typedef struct packed {
    rlc_mode_t mode;
    logic ack_en;
    logic crc_en;
  } rlc_cfg_t;
  // one host byte with its strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rlc_byte_t;
endpackage

// ### hw/rlc_ms_countdown.sv
// millisecond countdown timer with restart
`timescale 1ns/1ps
`include "rlc_consts.svh"
module rlc_ms_countdown import rlc_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic ms_tick,
  output logic [7:0] count,
  output logic expired
);
  // count and expiry pulse; a load always wins so a restart never also expires
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
      expired <= 1'b0;
    end else if (load) begin
      count <= load_val;
      expired <= 1'b0;
    end else if (ms_tick && count != 8'h00) begin
      count <= count - 8'h01;
      expired <= (count == 8'h01);
    end else begin
      expired <= 1'b0;
    end
  end
endmodule

// ### test/rlc_host_model.sv
// host processor model: framed commands and payload bytes on the command port
`timescale 1ns/1ps
module rlc_host_model import rlc_pkg::*; (
  input wire logic mclk,
  input wire rlc_byte_t reply_out,
  output rlc_byte_t host_in,
  output logic cmd_mode,
  output logic reply_ready
);
  // idle: no strobe, replies not accepted yet
  initial begin
    host_in = '0;
    cmd_mode = 1'b0;
    reply_ready = 1'b0;
  end

  // one byte per strobe; data is inverted once the strobe has gone
  task automatic put(input logic cmd, input logic [7:0] b);
    @(posedge mclk);
    #1;
    cmd_mode = cmd;
    host_in = {1'b1, b};
    @(posedge mclk);
    #1;
    host_in = {1'b0, ~b};
  endtask

  // write frame: header, size, address, value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    put(1'b1, 8'hFF);
    put(1'b1, 8'h02);
    put(1'b1, a);
    put(1'b1, v);
  endtask

  // read frame; stalls the reply a few cycles so it must stand, then takes three bytes
  task automatic rd(input logic [7:0] a, output logic [23:0] r);
    int n;
    put(1'b1, 8'hFF);
    put(1'b1, 8'h02);
    put(1'b1, 8'hFE);
    put(1'b1, a);
    repeat (3) @(posedge mclk);
    #1;
    reply_ready = 1'b1;
    r = '0;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      // bounded so a missing reply cannot hang the host
      do begin
        @(posedge mclk);
        n++;
      end while (reply_out.valid !== 1'b1 && n < 20);
      r = {r[15:0], reply_out.data};
    end
    #1;
    reply_ready = 1'b0;
  endtask
endmodule

// ### test/tb.sv
// self-checking bench for the radio link control settings block
`timescale 1ns/1ps
module tb import rlc_pkg::*;;
  localparam int MS = 10; // short millisecond keeps the run brief
  localparam logic [7:0] NM [8] = '{8'h14, 8'h16, 8'h17, 8'h04, 8'h06, 8'h07, 8'h05, 8'h15};
  localparam logic [7:0] RA [7] = '{8'h4F, 8'h50, 8'h52, 8'h53, 8'h54, 8'h4E, 8'h60};
  localparam logic [7:0] BC [5] = '{8'h00, 8'h01, 8'h06, 8'h02, 8'h03}; // baud codes; 0x06 waits as 9600 does
  localparam int ACKW [5] = '{170, 75, 75, 45, 30}; // ack wait in ms per baud code
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic radio_ack = 1'b0;
  logic rx_pkt_end = 1'b0;
  logic rx_crc_ok = 1'b0;
  logic cmd_mode, reply_ready;
  rlc_byte_t host_in, reply_out;
  rlc_cfg_t cfg_r;
  logic tx_start_r, retx_r, no_radio_ack_exception, rx_forward_r, rx_discard_r;
  logic [7:0] buf_level_r;
  int fail_count = 0;
  int cmp_count = 0;
  int regs [256]; // expected register contents
  int crc_cnt = 0; // expected failure count
  int cyc = 0, n_tx = 0, n_retx = 0, n_exc = 0, n_fwd = 0, n_dis = 0, t_tx = 0, t_exc = 0;

  always #10 mclk = ~mclk;

  rlc_link_ctl #(.MS_CYCLES(MS)) u_rlc_link_ctl (.mclk(mclk), .resetn(resetn), .cmd_mode(cmd_mode),
    .host_in(host_in), .reply_ready(reply_ready), .radio_ack(radio_ack), .rx_pkt_end(rx_pkt_end),
    .rx_crc_ok(rx_crc_ok), .reply_out(reply_out), .cfg_r(cfg_r), .tx_start_r(tx_start_r), .retx_r(retx_r),
    .no_radio_ack_exception(no_radio_ack_exception), .rx_forward_r(rx_forward_r),
    .rx_discard_r(rx_discard_r), .buf_level_r(buf_level_r));
  rlc_host_model u_rlc_host_model (.mclk(mclk), .reply_out(reply_out), .host_in(host_in),
    .cmd_mode(cmd_mode), .reply_ready(reply_ready));

  // tally output pulses and their edges; values seen are those before the edge
  always @(posedge mclk) begin
    cyc++;
    if (tx_start_r === 1'b1) begin
      n_tx++;
      t_tx = cyc;
    end
    if (retx_r === 1'b1) n_retx++;
    if (no_radio_ack_exception === 1'b1) begin
      n_exc++;
      t_exc = cyc;
    end
    if (rx_forward_r === 1'b1) n_fwd++;
    if (rx_discard_r === 1'b1) n_dis++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // write through the host and mirror it in the model; illegal values are kept out
  task automatic wrm(input logic [7:0] a, input logic [7:0] v);
    logic ok;
    u_rlc_host_model.wr(a, v);
    ok = (a != 8'h4F || v inside {8'h04, 8'h06, 8'h07, 8'h14, 8'h16, 8'h17}) && (a != 8'h53 || v < 8'h02)
      && (a != 8'h54 || (v != 8'h00 && v < 8'hC1));
    if (a == 8'h40 && v == 8'h00) crc_cnt = 0;
    if (ok && a inside {8'h4E, 8'h4F, 8'h50, 8'h52, 8'h53, 8'h54, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09})
      regs[a] = v;
  endtask

  task automatic rdm(input logic [7:0] a);
    logic [23:0] r;
    u_rlc_host_model.rd(a, r);
    chk(r[23:16], 8'h06);
    chk(r[15:8], a);
    chk(r[7:0], (a == 8'h40) ? 8'(crc_cnt) : 8'(regs[a]));
  endtask

  // live configuration lags the setting by one edge
  task automatic chk_cfg();
    logic [7:0] nm;
    logic [1:0] m;
    @(posedge mclk);
    #1;
    nm = 8'(regs[8'h4F]);
    m = (nm[3:0] == 4'h6) ? RLC_MODE_USER : (nm[3:0] == 4'h7) ? RLC_MODE_EXT : RLC_MODE_GUID;
    chk({4'h0, cfg_r.mode, cfg_r.ack_en, cfg_r.crc_en}, {4'h0, m, nm[4], regs[8'h53][0]});
  endtask

  // bounded wait for a pulse counter to move
  task automatic wait_n(ref int cnt, input int was, input int lim);
    int n = 0;
    while (cnt == was && n < lim) begin
      @(posedge mclk);
      n++;
    end
    #1;
  endtask

  initial begin
    int t, m, g, e, ok, x0, y0;
    void'($urandom(82613));
    regs[8'h4F] = 8'h04;
    regs[8'h50] = 8'h10;
    regs[8'h52] = 8'h03;
    regs[8'h53] = 8'h01;
    regs[8'h54] = 8'h40;
    regs[8'h4E] = 8'h01;
    repeat (20) @(posedge mclk);
    #1;
    resetn = 1'b1;
    chk_cfg();
    foreach (RA[i]) rdm(RA[i]); // reset values and an unmapped place
    // a wrong size byte must send the parser back to header hunt
    u_rlc_host_model.put(1'b1, 8'hFF);
    u_rlc_host_model.put(1'b1, 8'h03);
    rdm(8'h50);
    // every mode code, then two illegal ones that must not stick
    foreach (NM[i]) begin
      wrm(8'h4F, NM[i]);
      chk_cfg();
    end
    rdm(8'h4F);
    wrm(8'h04, 8'h16); // stored copy only, live mode unchanged
    rdm(8'h04);
    chk_cfg();
    // wait timer with restarts: gaps stay below the earliest expiry
    repeat (3) begin
      t = 2 + $urandom % 4; // host keeps the timeout at 2 or more
      wrm(8'h50, 8'(t));
      x0 = n_tx;
      m = 1 + $urandom % 3;
      for (int i = 0; i < m; i++) begin
        repeat ($urandom % ((t - 1) * MS - 6)) @(posedge mclk);
        u_rlc_host_model.put(1'b0, 8'($urandom));
        chk(buf_level_r, 8'(i + 1));
      end
      g = cyc;
      wait_n(n_tx, x0, 100 * MS);
      chk({7'h0, n_tx == x0 + 1 && t_tx - g >= (t - 1) * MS && t_tx - g <= t * MS + 5}, 8'h01);
      chk(buf_level_r, 8'h00);
    end
    // timer off: send exactly when the level reaches the unit
    wrm(8'h50, 8'h00);
    wrm(8'h54, 8'hC1);
    m = 1 + $urandom % 6;
    wrm(8'h54, 8'(m));
    rdm(8'h54);
    x0 = n_tx;
    for (int i = 0; i < m; i++) begin
      u_rlc_host_model.put(1'b0, 8'($urandom));
      repeat (3) @(posedge mclk);
      chk(8'(n_tx - x0), {7'h0, i == m - 1});
    end
    // acknowledged mode: wait per baud code with no retries
    wrm(8'h4F, 8'h14);
    wrm(8'h50, 8'h02);
    for (int b = 0; b < 5; b++) begin
      wrm(8'h4E, BC[b]);
      wrm(8'h52, 8'h00);
      x0 = n_tx;
      y0 = n_exc;
      e = n_retx;
      u_rlc_host_model.put(1'b0, 8'($urandom));
      wait_n(n_tx, x0, 10 * MS);
      wait_n(n_exc, y0, 200 * MS);
      chk({7'h0, t_exc - t_tx >= (ACKW[b] - 1) * MS && t_exc - t_tx <= ACKW[b] * MS + 4}, 8'h01);
      chk(8'(n_retx - e), 8'h00);
    end
    wrm(8'h52, 8'h02);
    x0 = n_tx;
    y0 = n_exc;
    e = n_retx;
    u_rlc_host_model.put(1'b0, 8'($urandom));
    wait_n(n_tx, x0, 10 * MS);
    wait_n(n_exc, y0, 1000 * MS);
    chk(8'(n_retx - e), 8'h02);
    chk(8'(n_exc - y0), 8'h01);
    // an acknowledge inside the wait ends it quietly
    x0 = n_tx;
    y0 = n_exc;
    e = n_retx;
    u_rlc_host_model.put(1'b0, 8'($urandom));
    wait_n(n_tx, x0, 10 * MS);
    repeat ($urandom % (20 * MS)) @(posedge mclk);
    radio_ack = 1'b1;
    @(posedge mclk);
    #1;
    radio_ack = 1'b0;
    repeat (100 * MS) @(posedge mclk);
    chk(8'(n_retx - e + n_exc - y0), 8'h00);
    // receive filter with checking on, then off; failures always counted
    for (e = 1; e >= 0; e--) begin
      wrm(8'h53, 8'(e));
      chk_cfg();
      repeat (6) begin
        ok = $urandom % 2;
        x0 = n_fwd;
        y0 = n_dis;
        @(posedge mclk);
        #1;
        rx_pkt_end = 1'b1;
        rx_crc_ok = ok[0];
        @(posedge mclk);
        #1;
        rx_pkt_end = 1'b0;
        rx_crc_ok = ~ok[0];
        repeat (2) @(posedge mclk);
        chk({6'h0, 1'(n_fwd - x0), 1'(n_dis - y0)}, {6'h0, !(e && !ok), e && !ok});
        if (!ok) crc_cnt++;
      end
      rdm(8'h40);
    end
    wrm(8'h53, 8'h02);
    wrm(8'h40, 8'h00);
    rdm(8'h40);
    rdm(8'h53);
    complete_run();
  end

  // watchdog well beyond the expected run length
  initial begin
    #1_500_000;
    fail_count++;
    complete_run();
  end
endmodule
